//--- rtl/host_irq_select_pkg.sv
// Constants for the host interrupt output selection block
package host_irq_select_pkg;
	// ---------------------------------------------------------------
	// Register map (word byte addresses)
	// ---------------------------------------------------------------
	localparam logic [3:0] ADDR_SELECT = 4'h0;
	localparam logic [3:0] ADDR_REQUEST = 4'h4;
	localparam logic [3:0] ADDR_STATUS3 = 4'h8;
	localparam logic [3:0] ADDR_CONTROL = 4'hc;
	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int SEL_STATUS3_BIT = 7;
	localparam int NUM_FRAMES = 7;
	localparam logic [7:0] SELECT_RESET = 8'h03;
	localparam logic [6:0] REQUEST_RESET = 7'h00;
	localparam logic [3:0] GP_RESET = 4'h0;
	localparam int CTRL_TWO_WAY_BIT = 0;
	// ---------------------------------------------------------------
	// Serial frame slots: start frame held low at least 4 clocks, then 3 per slot
	// ---------------------------------------------------------------
	localparam logic [7:0] SLOT_IRQ1 = 8'h01;
	localparam logic [7:0] SLOT_SMI = 8'h02;
	localparam logic [7:0] SLOT_IRQ6 = 8'h06;
	localparam logic [7:0] SLOT_IRQ9 = 8'h09;
	localparam logic [7:0] SLOT_IRQ10 = 8'h0a;
	localparam logic [7:0] SLOT_IRQ11 = 8'h0b;
	localparam logic [7:0] SLOT_IRQ12 = 8'h0c;
	localparam logic [7:0] CLOCKS_PER_SLOT = 8'h03;
	localparam logic [7:0] START_MIN_LOW = 8'h04;
endpackage

//--- rtl/host_irq_frame_map.sv
// Maps a serial frame slot number to its request index
`timescale 1ns/100ps
module host_irq_frame_map (
	input wire logic [7:0] slot_i,
	output logic hit_o,
	output logic [2:0] index_o
);
	// Index order matches select bits 0..6
	always_comb begin
		hit_o = 1'b1;
		index_o = 3'h0;
		case (slot_i)
			host_irq_select_pkg::SLOT_IRQ1: index_o = 3'h0;
			host_irq_select_pkg::SLOT_IRQ12: index_o = 3'h1;
			host_irq_select_pkg::SLOT_SMI: index_o = 3'h2;
			host_irq_select_pkg::SLOT_IRQ6: index_o = 3'h3;
			host_irq_select_pkg::SLOT_IRQ9: index_o = 3'h4;
			host_irq_select_pkg::SLOT_IRQ10: index_o = 3'h5;
			host_irq_select_pkg::SLOT_IRQ11: index_o = 3'h6;
			default: hit_o = 1'b0;
		endcase
	end
endmodule

//--- rtl/lpc_host_irq_select.sv
// Host interrupt output selection with serial interrupt frame driver
//
// Functional notes
// - Select bit clear: status three upper nibble always shows processing status.
// - Select bit set: processing status if two-way enable, else software bits.
// - One polarity bit per frame: IRQ1, IRQ6, IRQ9-12 and SMI.
// - Polarity 0: released when request clear, driven low when set.
// - Polarity 1: driven low when request clear, released when set.
`timescale 1ns/100ps
module lpc_host_irq_select (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] proc_status_i,
	input wire logic lclk_i,
	input wire logic serirq_i,
	output logic serirq_o,
	output logic serirq_oe_n_o
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		FR_IDLE = 3'b001,
		FR_START = 3'b010,
		FR_SLOTS = 3'b100
	} frame_state_t;

	typedef struct packed {
		logic [7:0] host_irq_output_select;
		logic [6:0] request;
		logic [3:0] gp_bits;
		logic two_way_register_enable;
		logic ack;
		logic [31:0] rdata;
		logic [1:0] lclk_sync;
		logic [1:0] sirq_sync;
		logic lclk_prev;
		frame_state_t fstate;
		logic [7:0] low_count;
		logic [7:0] slot;
		logic [7:0] phase;
		logic drive_low;
	} state_t;

	state_t r;
	state_t next_r;
	logic map_hit;
	logic [2:0] map_index;
	logic [3:0] status3_high;
	logic [31:0] read_mux;
	logic wb_req;
	logic lclk_rise;
	logic slot_request;
	logic slot_polarity;

	host_irq_frame_map u_map (
		.slot_i(r.slot),
		.hit_o(map_hit),
		.index_o(map_index)
	);

	assign wb_req = wb_cyc_i & wb_stb_i;
	assign lclk_rise = r.lclk_sync[1] & ~r.lclk_prev;
	assign slot_request = r.request[map_index];
	assign slot_polarity = r.host_irq_output_select[map_index];

	// ---------------------------------------------------------------
	// Status register three upper nibble
	// ---------------------------------------------------------------
	always_comb begin
		if (!r.host_irq_output_select[host_irq_select_pkg::SEL_STATUS3_BIT])
			status3_high = proc_status_i;
		else if (r.two_way_register_enable)
			status3_high = proc_status_i;
		else
			status3_high = r.gp_bits;
	end

	always_comb begin
		read_mux = 32'h0000_0000;
		case (wb_adr_i)
			host_irq_select_pkg::ADDR_SELECT:
				read_mux = {24'h00_0000, r.host_irq_output_select};
			host_irq_select_pkg::ADDR_REQUEST:
				read_mux = {25'h000_0000, r.request};
			host_irq_select_pkg::ADDR_STATUS3:
				read_mux = {24'h00_0000, status3_high, 4'h0};
			host_irq_select_pkg::ADDR_CONTROL:
				read_mux = {31'h0000_0000, r.two_way_register_enable};
			default: read_mux = 32'h0000_0000;
		endcase
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.ack = wb_req & ~r.ack;
		next_r.lclk_sync = {r.lclk_sync[0], lclk_i};
		next_r.sirq_sync = {r.sirq_sync[0], serirq_i};
		next_r.lclk_prev = r.lclk_sync[1];
		if (wb_req && !r.ack) begin
			next_r.rdata = read_mux;
			if (wb_we_i && wb_sel_i[0]) begin
				case (wb_adr_i)
					host_irq_select_pkg::ADDR_SELECT:
						next_r.host_irq_output_select = wb_dat_i[7:0];
					host_irq_select_pkg::ADDR_REQUEST:
						next_r.request = wb_dat_i[6:0];
					host_irq_select_pkg::ADDR_STATUS3:
						if (r.host_irq_output_select[
							host_irq_select_pkg::SEL_STATUS3_BIT] &&
							!r.two_way_register_enable)
							next_r.gp_bits = wb_dat_i[7:4];
					host_irq_select_pkg::ADDR_CONTROL:
						next_r.two_way_register_enable =
							wb_dat_i[host_irq_select_pkg::CTRL_TWO_WAY_BIT];
					default: next_r.rdata = r.rdata;
				endcase
			end
		end
		// Link side steps only on a sampled rising edge of the LPC clock
		if (lclk_rise) begin
			next_r.drive_low = 1'b0;
			case (r.fstate)
				FR_IDLE: begin
					next_r.low_count = 8'h00;
					if (!r.sirq_sync[1] && !r.drive_low)
						next_r.fstate = FR_START;
				end
				FR_START: begin
					if (!r.sirq_sync[1]) begin
						next_r.low_count = r.low_count + 8'h01;
					end else if (r.low_count >=
						host_irq_select_pkg::START_MIN_LOW - 8'h01) begin
						next_r.fstate = FR_SLOTS;
						next_r.slot = 8'h00;
						next_r.phase = 8'h01;
					end else begin
						next_r.fstate = FR_IDLE;
					end
				end
				FR_SLOTS: begin
					// A low seen while we release the line after slot IRQ12 ends the frame,
					// in any phase: a stop frame need not line up with a slot
					if (!r.sirq_sync[1] && !r.drive_low &&
						r.slot > host_irq_select_pkg::SLOT_IRQ12) begin
						next_r.fstate = FR_IDLE;
					end else if (r.phase ==
						host_irq_select_pkg::CLOCKS_PER_SLOT - 8'h01) begin
						next_r.phase = 8'h00;
						next_r.slot = r.slot + 8'h01;
					end else begin
						next_r.phase = r.phase + 8'h01;
					end
					if (map_hit && r.phase == 8'h02)
						next_r.drive_low =
							slot_request ^ slot_polarity;
					if (r.slot == 8'hff)
						next_r.fstate = FR_IDLE;
				end
				default: next_r.fstate = FR_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.host_irq_output_select <= host_irq_select_pkg::SELECT_RESET;
			r.request <= host_irq_select_pkg::REQUEST_RESET;
			r.gp_bits <= host_irq_select_pkg::GP_RESET;
			r.fstate <= FR_IDLE;
			r.lclk_sync <= 2'b00;
			r.sirq_sync <= 2'b11;
		end else begin
			r <= next_r;
		end
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.rdata;
	assign serirq_o = 1'b0;
	assign serirq_oe_n_o = ~r.drive_low;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_status_select: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!r.host_irq_output_select[host_irq_select_pkg::SEL_STATUS3_BIT]
		|-> status3_high == proc_status_i)
		else $error("status three not showing processing status");
	a_gp_bits_used: assert property (
		@(posedge clk_i) disable iff (rst_i)
		r.host_irq_output_select[host_irq_select_pkg::SEL_STATUS3_BIT] &&
		!r.two_way_register_enable |-> status3_high == r.gp_bits)
		else $error("status three not showing software bits");
	a_status_two_way: assert property (
		@(posedge clk_i) disable iff (rst_i)
		r.host_irq_output_select[host_irq_select_pkg::SEL_STATUS3_BIT] &&
		r.two_way_register_enable |-> status3_high == proc_status_i)
		else $error("two-way status not shown in status three");
	a_select_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wb_req && !r.ack && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == host_irq_select_pkg::ADDR_SELECT
		|=> r.host_irq_output_select == $past(wb_dat_i[7:0]))
		else $error("select register write lost");
	a_drive_slot_only: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!serirq_oe_n_o |-> r.fstate == FR_SLOTS)
		else $error("line driven outside slots");
	// The slot moves on at the same edge, so the request is taken from $past
	a_drive_pol_zero: assert property (
		@(posedge clk_i) disable iff (rst_i)
		lclk_rise && r.fstate == FR_SLOTS && map_hit &&
		r.phase == 8'h02 && !slot_polarity
		|=> !serirq_oe_n_o == $past(slot_request))
		else $error("wrong drive in slot with polarity zero");
	a_drive_pol_one: assert property (
		@(posedge clk_i) disable iff (rst_i)
		lclk_rise && r.fstate == FR_SLOTS && map_hit &&
		r.phase == 8'h02 && slot_polarity
		|=> serirq_oe_n_o == $past(slot_request))
		else $error("wrong drive in slot with polarity one");
	c_frame_start: cover property (@(posedge clk_i) r.fstate == FR_SLOTS);
	c_drive_low: cover property (@(posedge clk_i) !serirq_oe_n_o);
	c_gp_mode: cover property (@(posedge clk_i)
		r.host_irq_output_select[7] && !r.two_way_register_enable);
endmodule

//--- tb/serirq_host_model.sv
// Host end of the serial interrupt link: frame maker and slot sampler
`timescale 1ns/100ps
module serirq_host_model (
	output logic lclk_o,
	output logic host_low_o,
	input wire logic line_i
);
	initial begin
		lclk_o = 1'b0;
		host_low_o = 1'b0;
	end
	// Clock stands still between frames. The device answers a few system
	// clocks after each rise, so the line is read mid-phase at the fall;
	// a slot's third clock is the one that carries its level.
	task automatic run_frame(output logic [15:0] low);
		low = '0;
		// Off the system clock edges, so the pin sync sees no race
		#5;
		host_low_o = 1'b1;
		repeat (5) begin
			#80 lclk_o = 1'b1;
			#80 lclk_o = 1'b0;
		end
		host_low_o = 1'b0;
		for (int k = 0; k < 39; k++) begin
			#80 lclk_o = 1'b1;
			#80 lclk_o = 1'b0;
			if (line_i !== 1'b1) low[k/3] = 1'b1;
		end
		// Stop frame of two clocks, then one idle clock
		host_low_o = 1'b1;
		repeat (2) begin
			#80 lclk_o = 1'b1;
			#80 lclk_o = 1'b0;
		end
		host_low_o = 1'b0;
		#80 lclk_o = 1'b1;
		#80 lclk_o = 1'b0;
	endtask
endmodule

//--- tb/tb_lpc_host_irq_select.sv
// Self-checking testbench for the host interrupt selection block
`timescale 1ns/100ps
module tb_lpc_host_irq_select;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [3:0] ps = 4'h9;
	logic [31:0] wd = 32'h0;
	logic [31:0] rd;
	logic [31:0] q;
	logic [15:0] low;
	logic [15:0] exp;
	logic ack, oe_n, so, hlow, lclk, line;
	int fails = 0;
	int n_checks = 0;
	logic [7:0] slot [7] = '{8'h01, 8'h0c, 8'h02, 8'h06, 8'h09, 8'h0a, 8'h0b};
	always #10 clk_i = ~clk_i;
	// Pull-up on the shared line; either party may pull it low
	assign line = (hlow || (!oe_n && !so)) ? 1'b0 : 1'b1;
	lpc_host_irq_select dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.proc_status_i(ps), .lclk_i(lclk), .serirq_i(line),
		.serirq_o(so), .serirq_oe_n_o(oe_n));
	serirq_host_model host_u (.lclk_o(lclk), .host_low_o(hlow),
		.line_i(line));
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			$display("mismatch at %0t: no bus answer", $time);
		end
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, 4'h0, 0);
		chk(q, 32'h03, "select reset");
		wb(0, 4'h4, 0);
		chk(q, 32'h0, "request reset");
		wb(1, 4'h2, 32'hff);
		wb(0, 4'h2, 0);
		chk(q, 32'h0, "unmapped read");
		wb(1, 4'h0, 32'ha5);
		wb(0, 4'h0, 0);
		chk(q, 32'ha5, "select rw");
		$display("test registers done");
		wb(1, 4'h0, 32'h0);
		wb(1, 4'hc, 32'h1);
		wb(1, 4'h8, 32'h50);
		wb(0, 4'h8, 0);
		chk({28'h0, q[7:4]}, 32'h9, "status, two-way 1");
		wb(1, 4'hc, 32'h0);
		wb(1, 4'h8, 32'h50);
		wb(0, 4'h8, 0);
		chk({28'h0, q[7:4]}, 32'h9, "status, two-way 0");
		wb(1, 4'h0, 32'h80);
		wb(1, 4'h8, 32'h50);
		wb(0, 4'h8, 0);
		chk({28'h0, q[7:4]}, 32'h5, "status soft bits");
		wb(1, 4'hc, 32'h1);
		ps <= 4'h6;
		wb(0, 4'h8, 0);
		chk({28'h0, q[7:4]}, 32'h6, "status proc");
		$display("test status done");
		for (int i = 0; i < 7; i++) begin
			for (int v = 0; v < 4; v++) begin
				wb(1, 4'h0, 32'(v[1]) << i);
				wb(1, 4'h4, 32'(v[0]) << i);
				host_u.run_frame(low);
				exp = '0;
				if (v[0] != v[1]) exp[slot[i]] = 1'b1;
				chk({16'h0, low}, {16'h0, exp}, "frame");
			end
		end
		$display("test frames done");
		give_verdict();
	end
	initial begin
		#500000;
		fails++;
		$display("mismatch at %0t: watchdog", $time);
		give_verdict();
	end
endmodule
